// ==== src/rxst_cfg.svh ====
`ifndef RXST_CFG_SVH
`define RXST_CFG_SVH
// apb register byte offsets
`define RXST_OFF_CTRL      12'h000
`define RXST_OFF_STATUS    12'h004
`define RXST_OFF_IRQ_STAT  12'h008
`define RXST_OFF_IRQ_MASK  12'h00C
`define RXST_OFF_BOPAT     12'h010
`define RXST_OFF_ERRCNT    12'h014
// control field positions
`define RXST_CTRL_TXRST    0
`define RXST_CTRL_RXRST    1
`define RXST_CTRL_LOOP     2
`define RXST_CTRL_LOWFREQ  3
`define RXST_CTRL_SERBYTE  4
// reset values
`define RXST_CTRL_RST      5'h03
`define RXST_BOPAT_RST     8'hBC
// minimum pulse lengths in cycles
`define RXST_ERR_MIN       3
`define RXST_RM_MIN_SER    3
`define RXST_RM_MIN_NOSER  2
// prbs7 cycle length
`define RXST_PRBS_LEN      127
`endif

// ==== src/rxst_pkg.sv ====
`default_nettype none
package rxst_pkg;
   // flags for one decoded group, kept together so they align with data
   typedef struct packed {
      logic       ctrl;
      logic       code_err;
      logic       disp_err;
      logic       run_disp;
      logic [7:0] data;
   } rxst_sym_t;
   typedef enum logic [1:0] {RXST_IDLE, RXST_SYNC, RXST_CHECK} rxst_vstate_t;
endpackage
`default_nettype wire

// ==== src/rxst_prbs_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rxst_cfg.svh"
module rxst_prbs_gen (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       tx_reset,
   input  wire logic       low_freq,
   output logic [9:0]      pat
);
   logic [6:0] lfsr_reg;
   logic [6:0] lfsr_next;
   logic       lf_reg;
   logic       lf_next;
   // prbs7 advances one bit per cycle; low-frequency toggles five ones / zeros
   always_comb begin
      lfsr_next = lfsr_reg;
      lf_next   = lf_reg;
      if (tx_reset) begin
         lfsr_next = 7'h7F;
         lf_next   = 1'b0;
      end else begin
         lfsr_next = {lfsr_reg[5:0], lfsr_reg[6] ^ lfsr_reg[5]};
         lf_next   = ~lf_reg;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lfsr_reg <= 7'h7F;
         lf_reg   <= 1'b0;
      end else begin
         lfsr_reg <= lfsr_next;
         lf_reg   <= lf_next;
      end
   end
   assign pat = low_freq ? 10'h3E0 : {2'h0, lfsr_reg, 1'b0} | {9'h000, lf_reg};
endmodule // rxst_prbs_gen
`default_nettype wire

// ==== src/rxst_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module rxst_sync #(
   parameter int W = 1
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] d,
   output logic [W-1:0]      q
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   // two-stage synchroniser; first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg <= '0;
         s2_reg <= '0;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
      end
   end
   assign q = s2_reg;
endmodule // rxst_sync
`default_nettype wire

// ==== src/rxst_top.sv ====
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rxst_cfg.svh"
module rxst_top import rxst_pkg::*; #(
   parameter int NCH   = 1,
   parameter int CHW   = 10
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic [11:0]         paddr,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic [CHW-1:0]      rx_code_in,
   input  wire logic                rx_code_valid,
   input  wire logic                word_locked,
   input  wire logic                rm_full_in,
   input  wire logic                rm_empty_in,
   input  wire logic                byteord_restart,
   output logic [NCH*CHW-1:0]       rx_data_out,
   output logic                     rx_ctrl_flag,
   output logic                     rx_code_err,
   output logic                     rx_disp_err,
   output logic                     rx_run_disp,
   output logic                     rm_full,
   output logic                     rm_empty,
   output logic                     byteord_lock,
   output logic                     chk_done,
   output logic                     chk_err,
   output logic                     irq
);
   // refuse widths and counts the logic cannot serve
   if (CHW != 8 && CHW != 10) begin : g_bad_chw
      $error("channel width must be 8 or 10");
   end
   if (NCH < 1) begin : g_bad_nch
      $error("need at least one channel");
   end

   // control register and derived resets
   logic [4:0]  ctrl_reg;
   logic [4:0]  ctrl_next;
   logic [7:0]  bopat_reg;
   logic [7:0]  bopat_next;
   logic [3:0]  ist_reg;
   logic [3:0]  ist_next;
   logic [3:0]  imask_reg;
   logic [3:0]  imask_next;
   logic [31:0] prdata_next;
   logic        irq_next;
   logic        tx_rst;
   logic        rx_rst;
   logic        loop_en;
   logic        low_freq;
   assign tx_rst   = ctrl_reg[`RXST_CTRL_TXRST];
   assign rx_rst   = ctrl_reg[`RXST_CTRL_RXRST];
   assign loop_en  = ctrl_reg[`RXST_CTRL_LOOP];
   assign low_freq = ctrl_reg[`RXST_CTRL_LOWFREQ] && (CHW == 10);

   // pattern generator
   logic [9:0] gen_pat;
   rxst_prbs_gen u_gen (
      .pclk     (pclk),
      .presetn  (presetn),
      .tx_reset (tx_rst),
      .low_freq (low_freq),
      .pat      (gen_pat)
   );

   // async pins pass two flops
   logic [4:0] pin_s;
   rxst_sync #(.W(5)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({byteord_restart, rm_full_in, rm_empty_in, word_locked, rx_code_valid}),
      .q       (pin_s)
   );

   // received group: loopback selects generated pattern
   logic [CHW-1:0] code;
   logic           code_vld;
   assign code     = loop_en ? CHW'(gen_pat) : rx_code_in;
   assign code_vld = loop_en ? 1'b1 : pin_s[0];

   // decode: simplified, lower 8 bits are data, top bits classify
   rxst_sym_t sym;
   logic      rd_reg;
   logic      rd_next;
   logic [3:0] ones;
   logic [9:0] code_w;
   // group widened to ten bits so the class bits exist at any width
   assign code_w = 10'(code);
   // classify the group and track running disparity
   always_comb begin
      ones = '0;
      for (int i = 0; i < CHW; i++) ones = ones + 4'(code[i]);
      sym.data     = code[7:0];
      sym.ctrl     = (CHW == 10) && (code_w[9:8] == 2'b11);
      sym.code_err = (CHW == 10) && (ones < 4'd4 || ones > 4'd6);
      // disparity error implies the code error bit too
      sym.disp_err = (CHW == 10) && ((ones == 4'd6 && rd_reg) || (ones == 4'd4 && !rd_reg));
      if (sym.disp_err) sym.code_err = 1'b1;
      rd_next = rd_reg;
      if (code_vld && ones != 4'd5) rd_next = (ones > 4'd5);
      sym.run_disp = rd_next;
   end

   // verifier: counts a full cycle of groups without comparing, then checks each group
   rxst_vstate_t vst_reg;
   rxst_vstate_t vst_next;
   logic [6:0]   vcnt_reg;
   logic [6:0]   vcnt_next;
   logic         done_reg;
   logic         done_next;
   logic         err_reg;
   logic         err_next;
   logic [1:0]   ehold_reg;
   logic [1:0]   ehold_next;
   logic         seq_err_reg;
   logic         seq_err_next;
   logic [9:0]   exp_pat;
   logic         mismatch;
   logic         check_on;
   assign exp_pat  = gen_pat;
   assign check_on = (loop_en || pin_s[1]) && !low_freq;
   assign mismatch = CHW'(exp_pat) != code;
   // next state of the verifier, errors held for the minimum length
   always_comb begin
      vst_next     = vst_reg;
      vcnt_next    = vcnt_reg;
      done_next    = done_reg;
      err_next     = err_reg;
      ehold_next   = (ehold_reg != 2'd0) ? ehold_reg - 2'd1 : 2'd0;
      seq_err_next = seq_err_reg;
      if (rx_rst || !check_on) begin
         vst_next     = RXST_IDLE;
         vcnt_next    = '0;
         done_next    = 1'b0;
         err_next     = 1'b0;
         ehold_next   = 2'd0;
         seq_err_next = 1'b0;
      end else begin
         case (vst_reg)
            RXST_IDLE: if (pin_s[1] || loop_en) vst_next = RXST_SYNC;
            RXST_SYNC: begin
               vcnt_next = vcnt_reg + 7'd1;
               if (vcnt_reg == 7'(`RXST_PRBS_LEN - 1)) begin
                  vst_next  = RXST_CHECK;
                  done_next = 1'b1;
                  vcnt_next = '0;
               end
            end
            RXST_CHECK: begin
               vcnt_next = (vcnt_reg == 7'(`RXST_PRBS_LEN - 1)) ? 7'd0 : vcnt_reg + 7'd1;
               if (mismatch) begin
                  err_next     = 1'b1;
                  ehold_next   = 2'(`RXST_ERR_MIN - 1);
                  seq_err_next = 1'b1;
               end
               if (vcnt_reg == 7'(`RXST_PRBS_LEN - 1)) begin
                  // end of a sequence: clean one releases the flag
                  if (!seq_err_next && ehold_next == 2'd0) err_next = 1'b0;
                  seq_err_next = 1'b0;
               end
            end
            default: vst_next = RXST_IDLE;
         endcase
      end
   end
   // verifier state registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vst_reg     <= RXST_IDLE;
         vcnt_reg    <= '0;
         done_reg    <= 1'b0;
         err_reg     <= 1'b0;
         ehold_reg   <= 2'd0;
         seq_err_reg <= 1'b0;
      end else begin
         vst_reg     <= vst_next;
         vcnt_reg    <= vcnt_next;
         done_reg    <= done_next;
         err_reg     <= err_next;
         ehold_reg   <= ehold_next;
         seq_err_reg <= seq_err_next;
      end
   end

   // rate-match flags stretched to the minimum length
   logic [1:0] fhold_reg;
   logic [1:0] fhold_next;
   logic [1:0] ehld_reg;
   logic [1:0] ehld_next;
   logic [1:0] rm_min;
   assign rm_min = ctrl_reg[`RXST_CTRL_SERBYTE] ? 2'(`RXST_RM_MIN_SER - 1)
                                                 : 2'(`RXST_RM_MIN_NOSER - 1);
   // reload the hold counters while a flag input stands
   always_comb begin
      fhold_next = pin_s[3] ? rm_min : (fhold_reg != 2'd0 ? fhold_reg - 2'd1 : 2'd0);
      ehld_next  = pin_s[2] ? rm_min : (ehld_reg != 2'd0 ? ehld_reg - 2'd1 : 2'd0);
   end

   // byte ordering: restart on rising edge, lock on pattern in low byte
   logic rst_d_reg;
   logic lock_reg;
   logic lock_next;
   logic restart;
   assign restart = pin_s[4] && !rst_d_reg;
   // restart or rx reset wins over a pattern match
   always_comb begin
      lock_next = lock_reg;
      if (restart || rx_rst) lock_next = 1'b0;
      else if (code_vld && code[7:0] == bopat_reg) lock_next = 1'b1;
   end

   // output registers and channel replication
   wire logic [NCH*CHW-1:0] data_next;
   // each channel lane carries the same received group
   genvar gc;
   for (gc = 0; gc < NCH; gc++) begin : g_lane
      assign data_next[gc*CHW +: CHW] = code;
   end
   // every receive and status output comes straight from these flops; bus outputs and irq come from the register flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_reg       <= 1'b0;
         fhold_reg    <= 2'd0;
         ehld_reg     <= 2'd0;
         rst_d_reg    <= 1'b0;
         lock_reg     <= 1'b0;
         rx_data_out  <= '0;
         rx_ctrl_flag <= 1'b0;
         rx_code_err  <= 1'b0;
         rx_disp_err  <= 1'b0;
         rx_run_disp  <= 1'b0;
         rm_full      <= 1'b0;
         rm_empty     <= 1'b0;
         byteord_lock <= 1'b0;
         chk_done     <= 1'b0;
         chk_err      <= 1'b0;
      end else begin
         rd_reg       <= rx_rst ? 1'b0 : rd_next;
         fhold_reg    <= fhold_next;
         ehld_reg     <= ehld_next;
         rst_d_reg    <= pin_s[4];
         lock_reg     <= lock_next;
         // data and its flags registered together on pclk
         rx_data_out  <= data_next;
         rx_ctrl_flag <= sym.ctrl;
         rx_code_err  <= sym.code_err;
         rx_disp_err  <= sym.disp_err;
         rx_run_disp  <= sym.run_disp;
         rm_full      <= pin_s[3] || fhold_reg != 2'd0;
         rm_empty     <= pin_s[2] || ehld_reg != 2'd0;
         byteord_lock <= lock_next;
         chk_done     <= done_next;
         chk_err      <= err_next || ehold_next != 2'd0;
      end
   end

   // apb slave: zero wait, sticky status cleared by writing ones
   logic       wr;
   logic       rd;
   logic [3:0] ev;
   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign ev = {done_next & ~done_reg, err_next & ~err_reg, lock_next & ~lock_reg,
                pin_s[3] | pin_s[2]};
   // register writes, sticky status and read mux
   always_comb begin
      ctrl_next  = ctrl_reg;
      bopat_next = bopat_reg;
      imask_next = imask_reg;
      ist_next   = ist_reg;
      if (wr && paddr == `RXST_OFF_CTRL) ctrl_next = pwdata[4:0];
      if (wr && paddr == `RXST_OFF_BOPAT) bopat_next = pwdata[7:0];
      if (wr && paddr == `RXST_OFF_IRQ_MASK) imask_next = pwdata[3:0];
      if (wr && paddr == `RXST_OFF_IRQ_STAT) ist_next = ist_reg & ~pwdata[3:0];
      ist_next = ist_next | ev; // set beats clear
      irq_next = |(ist_next & imask_next);
      prdata_next = prdata;
      if (rd) begin
         case (paddr)
            `RXST_OFF_CTRL:     prdata_next = {27'h0, ctrl_reg};
            `RXST_OFF_STATUS:   prdata_next = {24'h0, rm_empty, rm_full, byteord_lock,
                                               chk_err, chk_done, rx_run_disp,
                                               rx_disp_err, rx_code_err};
            `RXST_OFF_IRQ_STAT: prdata_next = {28'h0, ist_reg};
            `RXST_OFF_IRQ_MASK: prdata_next = {28'h0, imask_reg};
            `RXST_OFF_BOPAT:    prdata_next = {24'h0, bopat_reg};
            `RXST_OFF_ERRCNT:   prdata_next = {25'h0, vcnt_reg};
            default:            prdata_next = 32'h0000_0000;
         endcase
      end
   end
   // register file and bus response flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg  <= `RXST_CTRL_RST;
         bopat_reg <= `RXST_BOPAT_RST;
         ist_reg   <= 4'h0;
         imask_reg <= 4'h0;
         prdata    <= 32'h0000_0000;
         irq       <= 1'b0;
         pready    <= 1'b0;
         pslverr   <= 1'b0;
      end else begin
         ctrl_reg  <= ctrl_next;
         bopat_reg <= bopat_next;
         ist_reg   <= ist_next;
         imask_reg <= imask_next;
         prdata    <= prdata_next;
         irq       <= irq_next;
         pready    <= psel && !penable;
         pslverr   <= psel && !penable && paddr > `RXST_OFF_ERRCNT;
      end
   end
endmodule // rxst_top
`default_nettype wire

// ==== dv/rxst_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module rxst_props #(
   parameter int NCH = 1,
   parameter int CHW = 10
) (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic [11:0]        paddr,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pready,
   input wire logic               pslverr,
   input wire logic               rm_full_in,
   input wire logic               rm_empty_in,
   input wire logic [NCH*CHW-1:0] rx_data_out,
   input wire logic               rx_code_err,
   input wire logic               rx_disp_err,
   input wire logic               rm_full,
   input wire logic               rm_empty,
   input wire logic               chk_done,
   input wire logic               chk_err
);
   // all checks run on the one core clock, off during reset
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ready; psel && !penable |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("no pready after setup");
   property p_ready_one; pready |=> !pready; endproperty
   a_ready_one: assert property (p_ready_one) else $error("pready held too long");
   property p_slverr; psel && !penable && paddr > 12'h014 |=> pready && pslverr; endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
   property p_err_done; chk_err |-> chk_done; endproperty
   a_err_done: assert property (p_err_done) else $error("check error without done");
   property p_err_len; $rose(chk_err) |=> chk_err [*2]; endproperty
   a_err_len: assert property (p_err_len) else $error("check error too short");
   property p_full_len; $rose(rm_full) |=> rm_full; endproperty
   a_full_len: assert property (p_full_len) else $error("full flag too short");
   property p_empty_len; $rose(rm_empty) |=> rm_empty; endproperty
   a_empty_len: assert property (p_empty_len) else $error("empty flag too short");
   property p_full_on; rm_full_in [*4] |-> rm_full; endproperty
   a_full_on: assert property (p_full_on) else $error("full flag not following");
   property p_empty_on; rm_empty_in [*4] |-> rm_empty; endproperty
   a_empty_on: assert property (p_empty_on) else $error("empty flag not following");
   property p_pair; rx_disp_err |-> rx_code_err; endproperty
   a_pair: assert property (p_pair) else $error("error pair 01 seen");
   property p_rep; rx_data_out[NCH*CHW-1 -: CHW] == rx_data_out[CHW-1:0]; endproperty
   a_rep: assert property (p_rep) else $error("channel lanes differ");
endmodule // rxst_props
bind rxst_top rxst_props #(.NCH(NCH), .CHW(CHW)) u_props (.pclk, .presetn, .paddr, .psel,
   .penable, .pready, .pslverr, .rm_full_in, .rm_empty_in, .rx_data_out, .rx_code_err,
   .rx_disp_err, .rm_full, .rm_empty, .chk_done, .chk_err);
`default_nettype wire

// ==== dv/rxst_fabric_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module rxst_fabric_model (
   input wire logic  pclk,
   input wire logic  presetn,
   input wire logic  restart_req,
   input wire logic  byteord_lock,
   output logic      byteord_restart,
   output logic      lock_seen
);
   logic [2:0] cnt_reg;
   logic [2:0] cnt_next;
   // one request gives one clean rising edge, held four cycles
   always_comb begin
      cnt_next = cnt_reg;
      if (restart_req && cnt_reg == 3'h0) begin
         cnt_next = 3'h4;
      end else if (cnt_reg != 3'h0) begin
         cnt_next = cnt_reg - 3'h1;
      end
   end
   // status is sampled in the core clock domain only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 3'h0;
         lock_seen <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         lock_seen <= byteord_lock;
      end
   end
   assign byteord_restart = (cnt_reg != 3'h0);
endmodule // rxst_fabric_model
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rxst_cfg.svh"
module tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic        rx_code_valid, word_locked, rm_full_in, rm_empty_in, restart_req;
   logic        byteord_restart, lock_seen, rx_ctrl_flag, rx_code_err, rx_disp_err;
   logic        rx_run_disp, rm_full, rm_empty, byteord_lock, chk_done, chk_err, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [9:0]  rx_code_in;
   logic [19:0] rx_data_out;
   int          mismatches, tests_run, cyc, n, m;
   rxst_top #(.NCH(2), .CHW(10)) u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .rx_code_in, .rx_code_valid, .word_locked,
      .rm_full_in, .rm_empty_in, .byteord_restart, .rx_data_out, .rx_ctrl_flag,
      .rx_code_err, .rx_disp_err, .rx_run_disp, .rm_full, .rm_empty, .byteord_lock,
      .chk_done, .chk_err, .irq);
   rxst_fabric_model u_fab (.pclk, .presetn, .restart_req, .byteord_lock,
      .byteord_restart, .lock_seen);
   // 40 MHz core clock
   always #12.5 pclk = ~pclk;
   task give_verdict;
      if (mismatches == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk_b(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task chk_w(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one apb transfer; waits for pready, then takes data and releases
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wait_done;
      n = 0;
      while (chk_done !== 1'b1 && n < 600) begin
         @(posedge pclk);
         n++;
      end
   endtask
   task t_reset;
      chk_b(chk_done, 1'b0);
      chk_b(rm_full, 1'b0);
      chk_b(irq, 1'b0);
      apb(1'b0, `RXST_OFF_CTRL, 32'h0);
      chk_w(rd, 32'h3);
      apb(1'b0, `RXST_OFF_BOPAT, 32'h0);
      chk_w(rd, 32'hBC);
      apb(1'b0, 12'h018, 32'h0);
      chk_b(er, 1'b1);
      chk_w(rd, 32'h0);
   endtask
   task t_decode;
      logic [9:0] c;
      for (int i = 0; i < 3; i++) begin
         c = (i == 0) ? 10'h2AA : (i == 1) ? 10'h000 : 10'h3F0;
         rx_code_in <= c;
         repeat (6) @(posedge pclk);
         chk_w({12'h0, rx_data_out}, {12'h0, c, c});
         chk_b(rx_code_err, i == 1);
         chk_b(rx_ctrl_flag, i == 2);
         chk_b(rx_disp_err, 1'b0);
         chk_b(rx_run_disp, i == 2);
      end
   endtask
   task t_rm;
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, `RXST_OFF_CTRL, s ? 32'h13 : 32'h03);
         rm_full_in <= 1'b1;
         rm_empty_in <= 1'b1;
         @(posedge pclk);
         rm_full_in <= 1'b0;
         rm_empty_in <= 1'b0;
         n = 0;
         m = 0;
         repeat (12) begin
            @(posedge pclk);
            n += rm_full;
            m += rm_empty;
         end
         chk_b(n >= (s ? 3 : 2), 1'b1);
         chk_b(m >= (s ? 3 : 2), 1'b1);
      end
      rm_full_in <= 1'b1;
      rm_empty_in <= 1'b1;
      repeat (6) @(posedge pclk);
      chk_b(rm_full, 1'b1);
      chk_b(rm_empty, 1'b1);
      rm_full_in <= 1'b0;
      rm_empty_in <= 1'b0;
      repeat (10) @(posedge pclk);
      chk_b(rm_full, 1'b0);
      chk_b(rm_empty, 1'b0);
   endtask
   task t_byteord;
      apb(1'b1, `RXST_OFF_CTRL, 32'h01);
      rx_code_in <= 10'h0BC;
      repeat (8) @(posedge pclk);
      chk_b(lock_seen, 1'b1);
      rx_code_in <= 10'h055;
      restart_req <= 1'b1;
      @(posedge pclk);
      restart_req <= 1'b0;
      repeat (12) @(posedge pclk);
      chk_b(byteord_lock, 1'b0);
   endtask
   task t_prbs;
      apb(1'b1, `RXST_OFF_BOPAT, 32'h01);
      apb(1'b1, `RXST_OFF_CTRL, 32'h04);
      word_locked <= 1'b1;
      wait_done;
      chk_b(chk_done, 1'b1);
      chk_b(chk_err, 1'b0);
      apb(1'b0, `RXST_OFF_IRQ_STAT, 32'h0);
      chk_b(rd[3], 1'b1);
      apb(1'b1, `RXST_OFF_IRQ_MASK, 32'h0);
      repeat (2) @(posedge pclk);
      chk_b(irq, 1'b0);
      apb(1'b1, `RXST_OFF_IRQ_MASK, 32'hF);
      repeat (2) @(posedge pclk);
      chk_b(irq, 1'b1);
      apb(1'b1, `RXST_OFF_IRQ_STAT, 32'hF);
      repeat (2) @(posedge pclk);
      chk_b(irq, 1'b0);
      apb(1'b1, `RXST_OFF_CTRL, 32'h06);
      repeat (4) @(posedge pclk);
      chk_b(chk_done, 1'b0);
      apb(1'b1, `RXST_OFF_CTRL, 32'h04);
      repeat (20) @(posedge pclk);
      chk_b(chk_done, 1'b0);
      wait_done;
      chk_b(chk_done, 1'b1);
      apb(1'b1, `RXST_OFF_CTRL, 32'h00);
      repeat (10) @(posedge pclk);
      chk_b(chk_err, 1'b1);
      chk_b(chk_done, 1'b1);
      apb(1'b1, `RXST_OFF_CTRL, 32'h04);
      repeat (300) @(posedge pclk);
      chk_b(chk_err, 1'b0);
   endtask
   task t_lowfreq;
      apb(1'b1, `RXST_OFF_CTRL, 32'h0E);
      apb(1'b1, `RXST_OFF_CTRL, 32'h0C);
      repeat (400) @(posedge pclk);
      chk_b(chk_done, 1'b0);
      chk_b(chk_err, 1'b0);
   endtask
   // hang guard
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         give_verdict;
      end
   end
   initial begin
      {pclk, presetn, psel, penable, pwrite, word_locked} = '0;
      {rm_full_in, rm_empty_in, restart_req} = '0;
      {paddr, pwdata, rx_code_in} = '0;
      rx_code_valid = 1'b1;
      {mismatches, tests_run, cyc} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_decode;
      t_rm;
      t_byteord;
      t_prbs;
      t_lowfreq;
      give_verdict;
   end
endmodule // tb_top
`default_nettype wire
